// ---- hw/video_ctrl_pkg.sv ----
// constants, field layouts and types for the video front-end control bank
package video_ctrl_pkg;

  // register pointer values
  localparam logic [7:0] REG_REVISION      = 8'h00;
  localparam logic [7:0] REG_DIV_HIGH      = 8'h01;
  localparam logic [7:0] REG_DIV_LOW       = 8'h02;
  localparam logic [7:0] REG_PLL_CTRL      = 8'h03;
  localparam logic [7:0] REG_PHASE         = 8'h04;
  localparam logic [7:0] REG_RED_GAIN      = 8'h05;
  localparam logic [7:0] REG_GREEN_GAIN    = 8'h06;
  localparam logic [7:0] REG_BLUE_GAIN     = 8'h07;
  localparam logic [7:0] REG_RED_TRIM      = 8'h08;
  localparam logic [7:0] REG_RED_TARGET    = 8'h09;
  localparam logic [7:0] REG_GREEN_TRIM    = 8'h0A;
  localparam logic [7:0] REG_GREEN_TARGET  = 8'h0B;
  localparam logic [7:0] REG_BLUE_TRIM     = 8'h0C;
  localparam logic [7:0] REG_BLUE_TARGET   = 8'h0D;
  localparam logic [7:0] REG_SYNC_WIDTH    = 8'h0E;
  localparam logic [7:0] REG_SLICE_ENTRY   = 8'h0F;
  localparam logic [7:0] REG_SLICE_EXIT    = 8'h10;
  localparam logic [7:0] REG_SOURCE_SEL    = 8'h11;
  localparam int         NUM_REGS          = 18;

  // values after reset
  localparam logic [7:0] RST_DIV_HIGH      = 8'h69;
  localparam logic [7:0] RST_DIV_LOW       = 8'hD0;
  localparam logic [7:0] RST_PLL_CTRL      = 8'h48;
  localparam logic [7:0] RST_PHASE         = 8'h80;
  localparam logic [7:0] RST_MIDSCALE      = 8'h80;
  localparam logic [7:0] RST_TRIM          = 8'h00;
  localparam logic [7:0] RST_SYNC_WIDTH    = 8'h20;
  localparam logic [7:0] RST_SLICE         = 8'h40;
  localparam logic [7:0] RST_SOURCE_SEL    = 8'h00;

  // writable bits per register
  localparam logic [7:0] MASK_FULL         = 8'hFF;
  localparam logic [7:0] MASK_DIV_LOW      = 8'hF0;
  localparam logic [7:0] MASK_PLL_CTRL     = 8'hFC;
  localparam logic [7:0] MASK_PHASE        = 8'hF8;
  localparam logic [7:0] MASK_SLICE        = 8'hFC;

  // serial port bit count per byte
  localparam logic [3:0] BITS_PER_BYTE     = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WRITE_ACK, ST_READ,
    ST_READ_ACK
  } port_state_t;

  // settings handed to the analog, clock and sync logic
  typedef struct packed {
    logic [11:0] pll_divider;
    logic [1:0]  oscillator_band;
    logic [2:0]  pump_current;
    logic        ext_clk_sel;
    logic [4:0]  sample_phase;
    logic [7:0]  red_gain;
    logic [7:0]  green_gain;
    logic [7:0]  blue_gain;
    logic [7:0]  red_trim;
    logic [7:0]  red_target;
    logic [7:0]  green_trim;
    logic [7:0]  green_target;
    logic [7:0]  blue_trim;
    logic [7:0]  blue_target;
    logic [7:0]  sync_width_limit;
    logic [5:0]  sync_on_green_entry;
    logic [5:0]  sync_on_green_exit;
    logic        hsync_from_sync_on_green;
    logic        hsync_manual;
    logic        vsync_from_sync_on_green;
    logic        vsync_manual;
    logic        channel_sel;
    logic        channel_manual;
    logic        digital_if_sel;
    logic        interface_manual;
  } ctrl_t;

  // writable bits of a register
  function automatic logic [7:0] reg_mask(input logic [7:0] idx);
    logic [7:0] m;
    m = MASK_FULL;
    if (idx == REG_REVISION) m = 8'h00;
    else if (idx == REG_DIV_LOW) m = MASK_DIV_LOW;
    else if (idx == REG_PLL_CTRL) m = MASK_PLL_CTRL;
    else if (idx == REG_PHASE) m = MASK_PHASE;
    else if (idx == REG_SLICE_ENTRY || idx == REG_SLICE_EXIT) m = MASK_SLICE;
    else if (idx >= 8'(NUM_REGS)) m = 8'h00;
    return m;
  endfunction

  // value of a register after reset
  function automatic logic [7:0] reg_reset(input logic [7:0] idx);
    logic [7:0] v;
    v = RST_MIDSCALE;
    if (idx == REG_DIV_HIGH) v = RST_DIV_HIGH;
    else if (idx == REG_DIV_LOW) v = RST_DIV_LOW;
    else if (idx == REG_PLL_CTRL) v = RST_PLL_CTRL;
    else if (idx == REG_PHASE) v = RST_PHASE;
    else if (idx == REG_RED_TRIM || idx == REG_GREEN_TRIM ||
             idx == REG_BLUE_TRIM) v = RST_TRIM;
    else if (idx == REG_SYNC_WIDTH) v = RST_SYNC_WIDTH;
    else if (idx == REG_SLICE_ENTRY || idx == REG_SLICE_EXIT) v = RST_SLICE;
    else if (idx == REG_SOURCE_SEL) v = RST_SOURCE_SEL;
    return v;
  endfunction

endpackage

// ---- hw/pin_sync.sv ----
// two-stage synchroniser for serial port pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int         WIDTH    = 2,
  parameter logic [1:0] IDLE_VAL = 2'h3
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // raw pins and synchronised copies
  input  wire logic [WIDTH-1:0] pin_raw,
  output logic      [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] meta_reg;

  generate
    if (WIDTH != 2) begin : g_bad_width
      $error("pin_sync serves exactly two pins");
    end
  endgenerate

  // first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_reg     <= IDLE_VAL;
      pin_sync_out <= IDLE_VAL;
    end else begin
      meta_reg     <= pin_raw;
      pin_sync_out <= meta_reg;
    end
  end

endmodule

// ---- hw/video_ctrl_regs.sv ----
// serial-port control register bank of the video front end
// Contract
// - outside controller reads and writes the bank over the 2-wire port
// - pointer 0x00 returns a fixed read-only 8-bit revision byte
// - pll divider: high byte at 0x01, four more bits at 0x02[7:4]
// - 0x03 holds oscillator band [7:6]=01, pump current [5:3]=001
// - 0x03 bit 2 picks external clock when set; resets to 0
// - 0x04 [7:3] picks sampling clock phase; resets to 10000
// - 0x05..0x07 red, green, blue gain codes; reset 0x80
// - 0x09, 0x0B, 0x0D offset target codes; reset 0x80
// - 0x08, 0x0A, 0x0C user offset trims; reset to zero
// - 0x0E composite sync width limit; resets to 0x20
// - 0x11 bits 7..4: manual or automatic hsync and vsync source
// - 0x11 bits 3..2: manual or automatic input channel choice
// - 0x11 bits 1..0: manual or automatic interface choice; reset zero
`timescale 1ns/1ps
module video_ctrl_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h4C, // arbitrary default
  parameter logic [7:0] REVISION = 8'h5A  // arbitrary value
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // 2-wire serial port pins
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe,
  // settings to analog, clock and sync logic
  output video_ctrl_pkg::ctrl_t     cfg
);

  generate
    if (DEV_ADDR == 7'h00) begin : g_bad_addr
      $error("device address 0 is the general call address");
    end
  endgenerate

  logic [1:0]                  pins_s;
  logic                        scl_s;
  logic                        sda_s;
  logic                        scl_d_reg;
  logic                        sda_d_reg;
  video_ctrl_pkg::port_state_t state_reg;
  video_ctrl_pkg::port_state_t state_next;
  logic [3:0]                  bit_cnt_reg;
  logic [7:0]                  rx_reg;
  logic [7:0]                  tx_reg;
  logic [7:0]                  ptr_reg;
  logic                        rw_reg;
  logic                        first_reg;
  logic                        nack_reg;
  logic                        oe_next;
  logic [7:0]                  bank_reg [1:video_ctrl_pkg::NUM_REGS-1];
  logic                        rst_seen_reg;

  // pins pass two flip-flops before use
  pin_sync #(
    .WIDTH    (2),
    .IDLE_VAL (2'h3)
  ) u_pin_sync (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .pin_raw      ({scl_in, sda_in}),
    .pin_sync_out (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // bus conditions and clock edges
  wire start_ev  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_ev   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire scl_rise  = scl_s & ~scl_d_reg;
  wire scl_fall  = ~scl_s & scl_d_reg;
  wire byte_done = (bit_cnt_reg == video_ctrl_pkg::BITS_PER_BYTE);
  wire addr_hit  = (rx_reg[7:1] == DEV_ADDR);
  wire in_addr   = (state_reg == video_ctrl_pkg::ST_ADDR);
  wire in_wr     = (state_reg == video_ctrl_pkg::ST_WRITE);
  wire in_wr_ack = (state_reg == video_ctrl_pkg::ST_WRITE_ACK);
  wire in_rd     = (state_reg == video_ctrl_pkg::ST_READ);
  wire in_rd_ack = (state_reg == video_ctrl_pkg::ST_READ_ACK);
  wire in_ad_ack = (state_reg == video_ctrl_pkg::ST_ADDR_ACK);

  // byte commit, pointer load and read load strobes
  wire wr_commit = in_wr & scl_fall & byte_done & ~start_ev & ~stop_ev;
  wire ptr_load  = wr_commit & first_reg;
  wire bank_we   = wr_commit & ~first_reg;
  wire tx_load   = scl_fall & ~start_ev & ~stop_ev &
                   ((in_ad_ack & rw_reg) | (in_rd_ack & ~nack_reg));
  wire mapped    = (ptr_reg != video_ctrl_pkg::REG_REVISION) &&
                   (ptr_reg < 8'(video_ctrl_pkg::NUM_REGS));
  wire [7:0] wr_mask = video_ctrl_pkg::reg_mask(ptr_reg);

  // read data for the current pointer
  wire [7:0] rd_byte = (ptr_reg == video_ctrl_pkg::REG_REVISION) ?
                       REVISION :
                       mapped ? bank_reg[ptr_reg[4:0]] : 8'h00;

  // delayed copies for edge and condition detection
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // transaction sequencing
  always_comb begin
    state_next = state_reg;
    if (stop_ev) begin
      state_next = video_ctrl_pkg::ST_IDLE;
    end else if (start_ev) begin
      state_next = video_ctrl_pkg::ST_ADDR;
    end else if (scl_fall) begin
      case (state_reg)
        video_ctrl_pkg::ST_ADDR: begin
          if (byte_done) begin
            state_next = addr_hit ? video_ctrl_pkg::ST_ADDR_ACK
                                  : video_ctrl_pkg::ST_IDLE;
          end
        end
        video_ctrl_pkg::ST_ADDR_ACK: begin
          state_next = rw_reg ? video_ctrl_pkg::ST_READ
                              : video_ctrl_pkg::ST_WRITE;
        end
        video_ctrl_pkg::ST_WRITE: begin
          if (byte_done) begin
            state_next = video_ctrl_pkg::ST_WRITE_ACK;
          end
        end
        video_ctrl_pkg::ST_WRITE_ACK: begin
          state_next = video_ctrl_pkg::ST_WRITE;
        end
        video_ctrl_pkg::ST_READ: begin
          if (byte_done) begin
            state_next = video_ctrl_pkg::ST_READ_ACK;
          end
        end
        video_ctrl_pkg::ST_READ_ACK: begin
          state_next = nack_reg ? video_ctrl_pkg::ST_IDLE
                                : video_ctrl_pkg::ST_READ;
        end
        default: begin
          state_next = state_reg;
        end
      endcase
    end
  end

  // data line drive: ack bits and zero read data bits pull low
  always_comb begin
    oe_next = sda_oe;
    if (start_ev || stop_ev) begin
      oe_next = 1'b0;
    end else if (tx_load) begin
      oe_next = ~rd_byte[7];
    end else if (scl_fall) begin
      if (in_addr && byte_done) begin
        oe_next = addr_hit;
      end else if (in_wr && byte_done) begin
        oe_next = 1'b1;
      end else if (in_rd && !byte_done) begin
        oe_next = ~tx_reg[6];
      end else if (in_rd || in_wr_ack || in_ad_ack || in_rd_ack) begin
        oe_next = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= video_ctrl_pkg::ST_IDLE;
      sda_oe    <= 1'b0;
      sda_out   <= 1'b0;
    end else begin
      state_reg <= state_next;
      sda_oe    <= oe_next;
      sda_out   <= 1'b0;
    end
  end

  // bit counter: counts clock rises within a byte
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bit_cnt_reg <= 4'h0;
    end else if (start_ev || (scl_fall && (in_ad_ack || in_wr_ack ||
                                           in_rd_ack))) begin
      bit_cnt_reg <= 4'h0;
    end else if (scl_rise && (in_addr || in_wr || in_rd)) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // receive shifter and master acknowledge sample
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_reg   <= 8'h00;
      nack_reg <= 1'b1;
    end else begin
      if (scl_rise && (in_addr || in_wr)) begin
        rx_reg <= {rx_reg[6:0], sda_s};
      end
      if (scl_rise && in_rd_ack) begin
        nack_reg <= sda_s;
      end
    end
  end

  // direction and first-byte flags
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rw_reg    <= 1'b0;
      first_reg <= 1'b0;
    end else begin
      if (in_addr && scl_fall && byte_done) begin
        rw_reg <= rx_reg[0];
      end
      if (in_ad_ack && scl_fall) begin
        first_reg <= 1'b1;
      end else if (wr_commit) begin
        first_reg <= 1'b0;
      end
    end
  end

  // transmit shifter
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_reg <= 8'h00;
    end else if (tx_load) begin
      tx_reg <= rd_byte;
    end else if (in_rd && scl_fall && !byte_done) begin
      tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  // register pointer, auto-increments after each written data byte and as each read byte is loaded
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ptr_reg <= 8'h00;
    end else if (ptr_load) begin
      ptr_reg <= rx_reg;
    end else if (bank_we || tx_load) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // register storage; undefined bits are masked off on write
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 1; i < video_ctrl_pkg::NUM_REGS; i++) begin
        bank_reg[i] <= video_ctrl_pkg::reg_reset(8'(i));
      end
    end else if (bank_we && mapped) begin
      bank_reg[ptr_reg[4:0]] <= rx_reg & wr_mask;
    end
  end

  // settings fields taken straight from the register bits
  assign cfg.pll_divider         = {bank_reg[1], bank_reg[2][7:4]};
  assign cfg.oscillator_band     = bank_reg[3][7:6];
  assign cfg.pump_current        = bank_reg[3][5:3];
  assign cfg.ext_clk_sel         = bank_reg[3][2];
  assign cfg.sample_phase        = bank_reg[4][7:3];
  assign cfg.red_gain            = bank_reg[5];
  assign cfg.green_gain          = bank_reg[6];
  assign cfg.blue_gain           = bank_reg[7];
  assign cfg.red_trim            = bank_reg[8];
  assign cfg.red_target          = bank_reg[9];
  assign cfg.green_trim          = bank_reg[10];
  assign cfg.green_target        = bank_reg[11];
  assign cfg.blue_trim           = bank_reg[12];
  assign cfg.blue_target         = bank_reg[13];
  assign cfg.sync_width_limit    = bank_reg[14];
  assign cfg.sync_on_green_entry = bank_reg[15][7:2];
  assign cfg.sync_on_green_exit  = bank_reg[16][7:2];

  // source overrides: a clear override bit leaves the choice automatic
  assign cfg.hsync_from_sync_on_green = bank_reg[17][7];
  assign cfg.hsync_manual             = bank_reg[17][6];
  assign cfg.vsync_from_sync_on_green = bank_reg[17][5];
  assign cfg.vsync_manual             = bank_reg[17][4];
  assign cfg.channel_sel              = bank_reg[17][3];
  assign cfg.channel_manual           = bank_reg[17][2];
  assign cfg.digital_if_sel           = bank_reg[17][1];
  assign cfg.interface_manual         = bank_reg[17][0];

  // marks the first cycle after reset release
  always_ff @(posedge sys_clk) begin
    rst_seen_reg <= ~rst_n;
  end

  chk_rev_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_load && ptr_reg == 8'h00 |=> tx_reg == REVISION)
    else $error("revision byte not loaded for pointer zero");

  chk_write_lands: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    bank_we && ptr_reg == 8'h05 |=> cfg.red_gain == $past(rx_reg))
    else $error("written byte did not reach its register");

  chk_div_reset: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rst_seen_reg |-> cfg.pll_divider == 12'h69D)
    else $error("divider reset value wrong");

  chk_pll_reset: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rst_seen_reg |-> cfg.oscillator_band == 2'h1 &&
                     cfg.pump_current == 3'h1 && !cfg.ext_clk_sel)
    else $error("clock control reset value wrong");

  chk_phase_reset: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rst_seen_reg |-> cfg.sample_phase == 5'h10 &&
                     cfg.sync_width_limit == 8'h20)
    else $error("phase or width limit reset value wrong");

  chk_level_reset: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rst_seen_reg |-> cfg.red_trim == 8'h00 && cfg.blue_target == 8'h80 &&
                     cfg.green_gain == 8'h80 && bank_reg[17] == 8'h00)
    else $error("gain, offset or select reset value wrong");

  chk_reserved_zero: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    bank_reg[2][3:0] == 4'h0 && bank_reg[3][1:0] == 2'h0 &&
    bank_reg[4][2:0] == 3'h0 && bank_reg[15][1:0] == 2'h0 &&
    bank_reg[16][1:0] == 2'h0)
    else $error("undefined register bit became set");

  chk_select_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !(bank_we && ptr_reg == 8'h11) |=> $stable(bank_reg[17]))
    else $error("source select changed without a write");

  chk_ack_drive: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    in_addr && scl_fall && byte_done && addr_hit && !start_ev && !stop_ev
    |=> sda_oe && state_reg == video_ctrl_pkg::ST_ADDR_ACK)
    else $error("address acknowledge not driven");

endmodule

// ---- testbench/serial_master_model.sv ----
// behavioural 2-wire bus master that drives the control bank
`timescale 1ns/1ps
module serial_master_model (
  // clock
  input  wire logic sys_clk,
  // bus lines
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_pull
);
  localparam int HALF = 8; // sys_clk cycles per scl phase

  // released bus at time zero
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // changes land just after a rising edge
  task automatic wait_clks(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // start or repeated start
  task automatic start_cond();
    sda_pull = 1'b0;
    wait_clks(HALF / 2);
    scl = 1'b1;
    wait_clks(HALF);
    sda_pull = 1'b1;
    wait_clks(HALF);
    scl = 1'b0;
    wait_clks(HALF / 2);
  endtask

  // stop: data rises while clock high
  task automatic stop_cond();
    sda_pull = 1'b1;
    wait_clks(HALF / 2);
    scl = 1'b1;
    wait_clks(HALF);
    sda_pull = 1'b0;
    wait_clks(HALF);
  endtask

  // one bit, sampled mid high phase
  task automatic send_bit(input logic b, output logic seen);
    sda_pull = !b;
    wait_clks(HALF / 2);
    scl = 1'b1;
    wait_clks(HALF / 2);
    seen = sda_wire;
    wait_clks(HALF / 2);
    scl = 1'b0;
    wait_clks(HALF / 2);
  endtask

  // byte msb first, ninth bit driven by nine, ack seen returned
  task automatic xfer_byte(input logic [7:0] tx, input logic nine,
                           output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      send_bit(tx[i], s);
      rx[i] = s;
    end
    send_bit(nine, s);
    ack = !s;
  endtask
endmodule

// ---- testbench/video_front_end_control_regs_tb_top.sv ----
// self-checking bench for the video front-end control bank
`timescale 1ns/1ps
module video_front_end_control_regs_tb_top;
  localparam logic [6:0] DEV_ADDR = 7'h3B; // arbitrary value
  localparam logic [7:0] REVISION = 8'hA6; // arbitrary value
  localparam logic [7:0] RST_TAB [18] = '{8'h00, 8'h69, 8'hD0, 8'h48,
    8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h80,
    8'h20, 8'h40, 8'h40, 8'h00};

  logic                  sys_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  scl;
  logic                  sda_pull;
  logic                  sda_out;
  logic                  sda_oe;
  wire                   sda_wire = !((sda_oe === 1'b1) | sda_pull);
  video_ctrl_pkg::ctrl_t cfg;
  logic [7:0]            shadow [18];
  logic [7:0]            got [20];
  int                    err_count = 0;
  int                    check_count = 0;
  int                    seed = 32'h70d8bf6f;

  always #20 sys_clk = !sys_clk;

  serial_master_model u_master (
    .sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull)
  );

  video_ctrl_regs #(.DEV_ADDR(DEV_ADDR), .REVISION(REVISION)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .cfg(cfg)
  );

  // writable bits of each pointer
  function automatic logic [7:0] wmask(input logic [7:0] p);
    case (p)
      8'h00: return 8'h00;
      8'h02: return 8'hF0;
      8'h03, 8'h0F, 8'h10: return 8'hFC;
      8'h04: return 8'hF8;
      default: return (p < 8'h12) ? 8'hFF : 8'h00;
    endcase
  endfunction

  // settings expected from the shadow bytes
  function automatic logic [122:0] cfg_exp();
    return {shadow[1], shadow[2][7:4], shadow[3][7:2], shadow[4][7:3],
      shadow[5], shadow[6], shadow[7], shadow[8], shadow[9], shadow[10],
      shadow[11], shadow[12], shadow[13], shadow[14], shadow[15][7:2],
      shadow[16][7:2], shadow[17]};
  endfunction

  task automatic check(input string what, input logic [127:0] seen,
                       input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic load_reset();
    foreach (shadow[i]) shadow[i] = RST_TAB[i];
    shadow[0] = REVISION;
  endtask

  // pointer then data bytes in one transfer
  task automatic wr(input logic [7:0] p, input logic [7:0] d [$]);
    logic [7:0] rx;
    logic       a;
    logic [7:0] m;
    u_master.start_cond();
    u_master.xfer_byte({DEV_ADDR, 1'b0}, 1'b1, rx, a);
    check("address ack", a, 1'b1);
    u_master.xfer_byte(p, 1'b1, rx, a);
    foreach (d[k]) begin
      u_master.xfer_byte(d[k], 1'b1, rx, a);
      check("data ack", a, 1'b1);
      m = wmask(8'(p + k));
      if (p + k < 18) shadow[p + k] = (shadow[p + k] & ~m) | (d[k] & m);
    end
    u_master.stop_cond();
  endtask

  // pointer write, repeated start, n read bytes
  task automatic compare_bank(input logic [7:0] p, input int n);
    logic [7:0] rx;
    logic       a;
    u_master.start_cond();
    u_master.xfer_byte({DEV_ADDR, 1'b0}, 1'b1, rx, a);
    u_master.xfer_byte(p, 1'b1, rx, a);
    u_master.start_cond();
    u_master.xfer_byte({DEV_ADDR, 1'b1}, 1'b1, rx, a);
    for (int k = 0; k < n; k++) begin
      u_master.xfer_byte(8'hFF, logic'(k == n - 1), rx, a);
      got[k] = rx;
    end
    u_master.stop_cond();
    for (int k = 0; k < n; k++)
      check("read back", got[k], (p + k < 18) ? shadow[p + k] : 8'h00);
    check("settings", cfg, cfg_exp());
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    logic [7:0] q [$];
    logic [7:0] p;
    logic [7:0] d;
    logic       a;
    load_reset();
    repeat (10) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    u_master.wait_clks(5);
    compare_bank(8'h00, 18);
    $display("test reset_values done");
    q = {8'hFF};
    wr(8'h00, q);
    wr(8'h12, q);
    q = {8'hFF, 8'hFF, 8'hFF, 8'h3C}; // runs on into the red gain byte
    wr(8'h02, q);
    compare_bank(8'h00, 20);
    $display("test read_only_unmapped done");
    u_master.start_cond();
    u_master.xfer_byte({DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, d, a);
    u_master.stop_cond();
    check("foreign address ack", a, 1'b0);
    q = {8'h54, 8'hA8}; // entry below exit
    wr(8'h0F, q);
    compare_bank(8'h0E, 3);
    for (int b = 0; b < 8; b++) begin
      q = {8'(1 << b)};
      wr(8'h11, q);
      check("settings", cfg, cfg_exp());
    end
    $display("test source_select done");
    for (int n = 0; n < 24; n++) begin
      p = 8'($unsigned($random(seed)) % 19);
      d = 8'($random(seed));
      if (p == 8'h0F) d = d & shadow[16];
      if (p == 8'h10) d = d | shadow[15];
      q = {d};
      wr(p, q);
      compare_bank(p, 1);
    end
    compare_bank(8'h00, 18);
    $display("test random_access done");
    rst_n = 1'b0;
    u_master.wait_clks(3);
    load_reset();
    check("settings in reset", cfg, cfg_exp());
    check("data drive in reset", sda_oe, 1'b0);
    check("data output level", sda_out, 1'b0);
    rst_n = 1'b1;
    u_master.wait_clks(5);
    compare_bank(8'h00, 18);
    $display("test second_reset done");
    complete_run();
  end

  // watchdog over the expected run length
  initial begin
    repeat (95000) @(posedge sys_clk);
    err_count++;
    $display("watchdog expired");
    complete_run();
  end
endmodule
